// ---- rtl/ccsl_gate.sv ----
// One stoppable clock channel with halt sampling
`timescale 1ns/1ps
`include "ccsl_regs.svh"
module ccsl_gate
	import ccsl_pkg::*;
#(
	parameter ccsl_count_type SAMPLE_EDGES = `CCSL_PCI_SAMPLE_EDGES
)
(
	input wire logic clk_in,
	input wire logic srst_in,
	ccsl_gate_if.gate g
);
	logic src_d;
	logic next_src_d;
	ccsl_count_type cnt;
	ccsl_count_type next_cnt;
	logic stopped;
	logic next_stopped;
	logic rise;
	logic fall;
	logic armed;

	always_comb
	begin
		rise = g.src & ~src_d;
		fall = ~g.src & src_d;
		armed = (cnt == SAMPLE_EDGES);
		next_src_d = g.src;
		next_cnt = cnt;
		next_stopped = stopped;
		// Halt sampled on rising source edges
		if (rise)
		begin
			if (!g.halt_n && g.en)
			begin
				if (!armed)
				begin
					next_cnt = cnt + 2'h1;
				end
			end
			else
			begin
				next_cnt = 2'h0;
			end
		end
		// Stop on the transition after sampling
		if (!stopped && armed && (rise || fall))
		begin
			next_stopped = 1'b1;
		end
		// Resume only at a rising edge
		else if (stopped && cnt == 2'h0 && rise)
		begin
			next_stopped = 1'b0;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			src_d <= 1'b0;
			cnt <= 2'h0;
			stopped <= 1'b0;
		end
		else
		begin
			src_d <= next_src_d;
			cnt <= next_cnt;
			stopped <= next_stopped;
		end
	end

	assign g.stopped = stopped;
	assign g.next_stopped = next_stopped;
	assign g.next_gated = next_stopped ? 1'b0 : g.src;

	property p_sample;
		@(posedge clk_in) disable iff (srst_in)
		(rise && !g.halt_n && g.en && cnt == 2'h0) |=> (cnt == 2'h1);
	endproperty
	a_sample: assert property (p_sample) else $error("halt not sampled on rise");

	property p_stop_after_edges;
		@(posedge clk_in) disable iff (srst_in)
		$rose(stopped) |-> ($past(cnt) == SAMPLE_EDGES) && ($past(src_d) != $past(g.src));
	endproperty
	a_stop_after_edges: assert property (p_stop_after_edges) else $error("early stop");

	property p_resume_rise;
		@(posedge clk_in) disable iff (srst_in)
		$fell(stopped) |-> $past(g.src) && !$past(src_d);
	endproperty
	a_resume_rise: assert property (p_resume_rise) else $error("resume off rise");
endmodule : ccsl_gate

// ---- rtl/ccsl_gate_if.sv ----
// Carrier between the top and one clock gate
`timescale 1ns/1ps
interface ccsl_gate_if;
	logic src;
	logic halt_n;
	logic en;
	logic stopped;
	logic next_stopped;
	logic next_gated;
	modport gate (input src, input halt_n, input en, output stopped, output next_stopped,
		output next_gated);
	modport user (output src, output halt_n, output en, input stopped, input next_stopped,
		input next_gated);
endinterface : ccsl_gate_if

// ---- rtl/ccsl_pkg.sv ----
// Types of the clock stop and strap latch block
`include "ccsl_regs.svh"
package ccsl_pkg;
	typedef logic [`CCSL_STRAP_W-1:0] ccsl_strap_type;
	typedef logic [`CCSL_PCI_N-1:0] ccsl_pci_type;
	typedef logic [`CCSL_FREE_N-1:0] ccsl_free_type;
	typedef logic [`CCSL_CPU_N-1:0] ccsl_cpu_type;
	typedef logic [`CCSL_DRIVE_W-1:0] ccsl_drive_type;
	typedef logic [1:0] ccsl_count_type;
endpackage : ccsl_pkg

// ---- rtl/ccsl_regs.svh ----
// Constants of the clock stop and strap latch block
`ifndef CCSL_REGS_SVH
`define CCSL_REGS_SVH
`define CCSL_STRAP_W 5
`define CCSL_STRAP_RESET 5'h00
`define CCSL_PCI_N 6
`define CCSL_FREE_N 2
`define CCSL_CPU_N 2
`define CCSL_DRIVE_W 2
`define CCSL_PCI_SAMPLE_EDGES 2'h1
`define CCSL_CPU_SAMPLE_EDGES 2'h2
`endif

// ---- rtl/ccsl_top.sv ----
// Clock output gating and power-up strap latch
`timescale 1ns/1ps
`include "ccsl_regs.svh"
// Notes on behaviour
// - During power-up the shared pins are inputs and their levels are latched.
// - After power-on reset the shared pins drive clocks; latched values stay.
// - PCI halt low holds PCI and stoppable free clocks low from next fall.
// - PCI halt is sampled at the next rising clock edge; setup is the caller's.
// - CPU halt stops stoppable CPU pairs after two sampled edges, next transition.
// - Stopped CPU pair rests true low, complement high.
// - Stopping does not change the programmed drive current setting.
// - While stopped, true is driven at multiplier current, complement floats.
module ccsl_top
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic por_in,
	input wire ccsl_pkg::ccsl_strap_type strap_pin_in,
	input wire ccsl_pkg::ccsl_strap_type shared_src_in,
	output ccsl_pkg::ccsl_strap_type strap_pin_out,
	output ccsl_pkg::ccsl_strap_type strap_pin_oe_out,
	output ccsl_pkg::ccsl_strap_type strap_value_out,
	input wire logic pci_clock_halt_n_in,
	input wire logic cpu_clock_halt_n_in,
	input wire ccsl_pkg::ccsl_pci_type pci_src_in,
	input wire ccsl_pkg::ccsl_free_type free_src_in,
	input wire ccsl_pkg::ccsl_free_type free_stoppable_in,
	input wire ccsl_pkg::ccsl_cpu_type cpu_src_in,
	input wire ccsl_pkg::ccsl_cpu_type cpu_stoppable_in,
	input wire ccsl_pkg::ccsl_drive_type cpu_drive_cfg_in,
	input wire logic current_multiplier_sel_in,
	output ccsl_pkg::ccsl_pci_type pci_clk_out,
	output ccsl_pkg::ccsl_free_type free_pci_clk_out,
	output ccsl_pkg::ccsl_cpu_type cpu_true_out,
	output ccsl_pkg::ccsl_cpu_type cpu_comp_out,
	output ccsl_pkg::ccsl_cpu_type cpu_true_oe_out,
	output ccsl_pkg::ccsl_cpu_type cpu_comp_oe_out,
	output ccsl_pkg::ccsl_drive_type cpu_drive_out,
	output ccsl_pkg::ccsl_cpu_type cpu_current_mult_out
);
	import ccsl_pkg::*;

	ccsl_strap_type strap;
	ccsl_strap_type next_strap;
	ccsl_strap_type pin_oe;
	ccsl_strap_type next_pin_oe;
	ccsl_strap_type pin_o;
	ccsl_strap_type next_pin_o;
	ccsl_pci_type pci_o;
	ccsl_pci_type next_pci_o;
	ccsl_free_type free_o;
	ccsl_free_type next_free_o;
	ccsl_cpu_type true_o;
	ccsl_cpu_type next_true_o;
	ccsl_cpu_type comp_o;
	ccsl_cpu_type next_comp_o;
	ccsl_cpu_type true_oe;
	ccsl_cpu_type next_true_oe;
	ccsl_cpu_type comp_oe;
	ccsl_cpu_type next_comp_oe;
	ccsl_cpu_type mult;
	ccsl_cpu_type next_mult;
	ccsl_drive_type drive;
	ccsl_drive_type next_drive;
	ccsl_cpu_type cpu_stopped;

	ccsl_gate_if pci_if [`CCSL_PCI_N] ();
	ccsl_gate_if free_if [`CCSL_FREE_N] ();
	ccsl_gate_if cpu_if [`CCSL_CPU_N] ();

	// PCI clocks, always stoppable
	genvar i;
	generate
		for (i = 0; i < `CCSL_PCI_N; i++)
		begin : g_pci
			assign pci_if[i].src = pci_src_in[i];
			assign pci_if[i].halt_n = pci_clock_halt_n_in;
			assign pci_if[i].en = 1'b1;
			assign next_pci_o[i] = pci_if[i].next_gated;
			ccsl_gate #(.SAMPLE_EDGES(`CCSL_PCI_SAMPLE_EDGES)) u_gate
			(
				.clk_in(clk_in),
				.srst_in(srst_in),
				.g(pci_if[i])
			);
		end
		for (i = 0; i < `CCSL_FREE_N; i++)
		begin : g_free
			assign free_if[i].src = free_src_in[i];
			assign free_if[i].halt_n = pci_clock_halt_n_in;
			assign free_if[i].en = free_stoppable_in[i];
			assign next_free_o[i] = free_if[i].next_gated;
			ccsl_gate #(.SAMPLE_EDGES(`CCSL_PCI_SAMPLE_EDGES)) u_gate
			(
				.clk_in(clk_in),
				.srst_in(srst_in),
				.g(free_if[i])
			);
		end
		for (i = 0; i < `CCSL_CPU_N; i++)
		begin : g_cpu
			assign cpu_if[i].src = cpu_src_in[i];
			assign cpu_if[i].halt_n = cpu_clock_halt_n_in;
			assign cpu_if[i].en = cpu_stoppable_in[i];
			assign cpu_stopped[i] = cpu_if[i].stopped;
			always_comb
			begin
				if (cpu_if[i].next_stopped)
				begin
					next_true_o[i] = 1'b0;
					next_comp_o[i] = 1'b1;
					next_true_oe[i] = 1'b1;
					next_comp_oe[i] = 1'b0;
				end
				else
				begin
					next_true_o[i] = cpu_src_in[i];
					next_comp_o[i] = ~cpu_src_in[i];
					next_true_oe[i] = 1'b1;
					next_comp_oe[i] = 1'b1;
				end
				next_mult[i] = current_multiplier_sel_in;
			end
			ccsl_gate #(.SAMPLE_EDGES(`CCSL_CPU_SAMPLE_EDGES)) u_gate
			(
				.clk_in(clk_in),
				.srst_in(srst_in),
				.g(cpu_if[i])
			);
		end
	endgenerate

	// Strap latch and shared pin direction
	always_comb
	begin
		next_strap = strap;
		next_pin_oe = '0;
		next_pin_o = '0;
		next_drive = cpu_drive_cfg_in;
		if (por_in)
		begin
			next_strap = strap_pin_in;
		end
		else
		begin
			next_pin_oe = '1;
			next_pin_o = shared_src_in;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			strap <= `CCSL_STRAP_RESET;
			pin_oe <= '0;
			pin_o <= '0;
			pci_o <= '0;
			free_o <= '0;
			true_o <= '0;
			comp_o <= '1;
			true_oe <= '0;
			comp_oe <= '0;
			mult <= '0;
			drive <= '0;
		end
		else
		begin
			strap <= next_strap;
			pin_oe <= next_pin_oe;
			pin_o <= next_pin_o;
			pci_o <= next_pci_o;
			free_o <= next_free_o;
			true_o <= next_true_o;
			comp_o <= next_comp_o;
			true_oe <= next_true_oe;
			comp_oe <= next_comp_oe;
			mult <= next_mult;
			drive <= next_drive;
		end
	end

	assign strap_value_out = strap;
	assign strap_pin_oe_out = pin_oe;
	assign strap_pin_out = pin_o;
	assign pci_clk_out = pci_o;
	assign free_pci_clk_out = free_o;
	assign cpu_true_out = true_o;
	assign cpu_comp_out = comp_o;
	assign cpu_true_oe_out = true_oe;
	assign cpu_comp_oe_out = comp_oe;
	assign cpu_current_mult_out = mult;
	assign cpu_drive_out = drive;

	property p_strap_capture;
		@(posedge clk_in) disable iff (srst_in)
		(por_in && !srst_in) |=> (strap_value_out == $past(strap_pin_in))
			&& (strap_pin_oe_out == '0);
	endproperty
	a_strap_capture: assert property (p_strap_capture) else $error("strap not latched");

	property p_strap_hold;
		@(posedge clk_in) disable iff (srst_in)
		(!por_in && $past(!por_in)) |=> $stable(strap_value_out) && (strap_pin_oe_out == '1)
			&& (strap_pin_out == $past(shared_src_in));
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("shared pins wrong after reset");

	property p_pci_low;
		@(posedge clk_in) disable iff (srst_in)
		pci_if[0].next_stopped |=> (pci_clk_out[0] == 1'b0);
	endproperty
	a_pci_low: assert property (p_pci_low) else $error("pci clock not held low");

	property p_cpu_rest;
		@(posedge clk_in) disable iff (srst_in)
		cpu_stopped[0] |-> (cpu_true_out[0] == 1'b0) && (cpu_comp_out[0] == 1'b1);
	endproperty
	a_cpu_rest: assert property (p_cpu_rest) else $error("cpu stop state wrong");

	property p_drive_kept;
		@(posedge clk_in) disable iff (srst_in)
		$rose(cpu_stopped[0]) |-> (cpu_drive_out == $past(cpu_drive_cfg_in));
	endproperty
	a_drive_kept: assert property (p_drive_kept) else $error("drive changed at stop");

	property p_cpu_float;
		@(posedge clk_in) disable iff (srst_in)
		cpu_stopped[0] |-> cpu_true_oe_out[0] && !cpu_comp_oe_out[0]
			&& (cpu_current_mult_out[0] == $past(current_multiplier_sel_in));
	endproperty
	a_cpu_float: assert property (p_cpu_float) else $error("cpu drive state wrong");
endmodule : ccsl_top

// ---- tb/ccsl_chipset_model.sv ----
// Chipset model driving the active-low halt inputs
`timescale 1ns/1ps
module ccsl_chipset_model
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic pci_stop_req_in,
	input wire logic cpu_stop_req_in,
	output logic pci_clock_halt_n_out,
	output logic cpu_clock_halt_n_out
);
	// Changes just after an edge, a full cycle of setup
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			pci_clock_halt_n_out <= 1'b1;
			cpu_clock_halt_n_out <= 1'b1;
		end
		else
		begin
			pci_clock_halt_n_out <= ~pci_stop_req_in;
			cpu_clock_halt_n_out <= ~cpu_stop_req_in;
		end
	end
endmodule : ccsl_chipset_model

// ---- tb/ccsl_top_tb_top.sv ----
// Testbench for the clock stop and strap latch block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module ccsl_top_tb_top;
	import ccsl_pkg::*;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic por_in = 1'b1;
	logic src = 1'b0;
	logic src_q = 1'b0;
	logic [2:0] ph = 3'h0;
	logic pci_req = 1'b0;
	logic cpu_req = 1'b0;
	logic mult = 1'b1;
	ccsl_strap_type strap_res = 5'h15;
	ccsl_free_type free_stop = 2'h1;
	ccsl_cpu_type cpu_stop = 2'h1;
	ccsl_drive_type drive = 2'h2;
	ccsl_strap_type pin_out, pin_oe, strap_val, pin_lvl;
	ccsl_pci_type pci_o;
	ccsl_free_type free_o;
	ccsl_cpu_type ct, cc, ct_oe, cc_oe, mult_o;
	ccsl_drive_type drv_o;
	logic pci_halt_n, cpu_halt_n;
	int fail_count = 0;
	int n_tests = 0;
	always #25 clk_in = ~clk_in;
	// Slow source clock, each level held four cycles
	always @(posedge clk_in)
	begin
		ph <= ph + 3'h1;
		if (ph == 3'h3 || ph == 3'h7)
			src <= ~src;
		src_q <= src;
	end
	// Shared pin level: driver when enabled, else the strap resistor
	assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & strap_res);
	ccsl_chipset_model chipset (.clk_in(clk_in), .srst_in(srst_in), .pci_stop_req_in(pci_req),
		.cpu_stop_req_in(cpu_req), .pci_clock_halt_n_out(pci_halt_n),
		.cpu_clock_halt_n_out(cpu_halt_n));
	ccsl_top dut (.clk_in(clk_in), .srst_in(srst_in), .por_in(por_in), .strap_pin_in(pin_lvl),
		.shared_src_in({5{src}}), .strap_pin_out(pin_out), .strap_pin_oe_out(pin_oe),
		.strap_value_out(strap_val), .pci_clock_halt_n_in(pci_halt_n),
		.cpu_clock_halt_n_in(cpu_halt_n), .pci_src_in({6{src}}), .free_src_in({2{src}}),
		.free_stoppable_in(free_stop), .cpu_src_in({2{src}}), .cpu_stoppable_in(cpu_stop),
		.cpu_drive_cfg_in(drive), .current_multiplier_sel_in(mult), .pci_clk_out(pci_o),
		.free_pci_clk_out(free_o), .cpu_true_out(ct), .cpu_comp_out(cc),
		.cpu_true_oe_out(ct_oe), .cpu_comp_oe_out(cc_oe), .cpu_drive_out(drv_o),
		.cpu_current_mult_out(mult_o));
	task automatic go(input int n);
		repeat (n) @(negedge clk_in);
	endtask : go
	task automatic edge_to(input logic v);
		int k;
		k = 0;
		do begin go(1); k++; end while (src_q !== ~v && k < 20);
		do begin go(1); k++; end while (src_q !== v && k < 40);
	endtask : edge_to
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task automatic strap_test;
		`CHK("strap_value", 5'h15, strap_val)
		`CHK("strap_oe", 5'h00, pin_oe)
		@(posedge clk_in) por_in <= 1'b0;
		go(3);
		repeat (8)
		begin
			`CHK("strap_oe_after", 5'h1f, pin_oe)
			`CHK("strap_kept", 5'h15, strap_val)
			`CHK("shared_clk", {5{src_q}}, pin_out)
			go(1);
		end
	endtask : strap_test
	task automatic pci_test;
		edge_to(0);
		@(posedge clk_in) pci_req <= 1'b1;
		edge_to(1);
		go(2);
		`CHK("pci_high_before", 6'h3f, pci_o)
		edge_to(0);
		repeat (16)
		begin
			`CHK("pci_held", 6'h00, pci_o)
			`CHK("free_held", {src_q, 1'b0}, free_o)
			go(1);
		end
		@(posedge clk_in) pci_req <= 1'b0;
		edge_to(1);
		`CHK("pci_no_runt", 6'h00, pci_o)
		edge_to(1);
		repeat (4)
		begin
			`CHK("pci_full_high", 6'h3f, pci_o)
			go(1);
		end
	endtask : pci_test
	task automatic cpu_test;
		edge_to(0);
		@(posedge clk_in) cpu_req <= 1'b1;
		edge_to(1);
		edge_to(0);
		edge_to(1);
		`CHK("cpu_second_rise", 2'h3, ct)
		edge_to(0);
		repeat (16)
		begin
			`CHK("cpu_true", {src_q, 1'b0}, ct)
			`CHK("cpu_comp", {~src_q, 1'b1}, cc)
			`CHK("cpu_true_oe", 2'h3, ct_oe)
			`CHK("cpu_comp_oe", 2'h2, cc_oe)
			`CHK("cpu_mult", 2'h3, mult_o)
			`CHK("cpu_drive", 2'h2, drv_o)
			go(1);
		end
		@(posedge clk_in) cpu_req <= 1'b0;
		edge_to(1);
		`CHK("cpu_no_runt", 2'h2, ct)
		edge_to(1);
		repeat (4)
		begin
			`CHK("cpu_full_high", 2'h3, ct)
			`CHK("cpu_comp_low", 2'h0, cc)
			go(1);
		end
	endtask : cpu_test
	initial
	begin
		repeat (2000) @(posedge clk_in);
		fail_count++;
		end_sim();
	end
	initial
	begin
		repeat (10) @(posedge clk_in);
		srst_in <= 1'b0;
		go(2);
		strap_test();
		pci_test();
		cpu_test();
		end_sim();
	end
endmodule : ccsl_top_tb_top
